// [logic/card_pwr_pkg.sv]
// Package of constants and types for the card power-up sequencer
package card_pwr_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned READY_TIME_US = 1000;
  localparam int unsigned READY_CYCLES = READY_TIME_US * CLK_MHZ;
  localparam int unsigned PREP_CLOCKS = 74;
  localparam int unsigned CNT_W = 20;
  localparam logic [1:0] IFACE_BUS = 2'h0;
  localparam logic [1:0] IFACE_SPI = 2'h1;
  localparam logic [1:0] IFACE_LANE = 2'h2;
  localparam logic [1:0] IFACE_PCIE = 2'h3;
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_PREP = 3'h1,
    ST_IDLE = 3'h3,
    ST_FAULT = 3'h2
  } pwr_state_t;
endpackage

// [logic/supply_sync_if.sv]
// Interface carrying synchronised supply-good levels
`timescale 1ns/1ps
interface supply_sync_if;
  logic main_ok;
  logic second_ok;
  logic low_v_ok;
  modport src (output main_ok, output second_ok, output low_v_ok);
  modport dst (input main_ok, input second_ok, input low_v_ok);
endinterface

// [logic/supply_sync.sv]
// Two-flop synchronisers for supply-good detector pins
`timescale 1ns/1ps
module supply_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Raw detector levels
  input wire logic [2:0] raw_ok,
  // Synchronised levels
  supply_sync_if.src sync
);
  logic [2:0] s1_q;
  logic [2:0] s1_d;
  logic [2:0] s2_q;
  logic [2:0] s2_d;
  always_comb begin
    s1_d = clk_en ? raw_ok : s1_q;
    s2_d = clk_en ? s1_q : s2_q;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end
  assign sync.main_ok = s2_q[0];
  assign sync.second_ok = s2_q[1];
  assign sync.low_v_ok = s2_q[2];
endmodule

// [logic/card_power_up_sequencer.sv]
// Card-side power-up sequencer: supply detection to idle-state readiness
// ****************************************
// Operation
// - Accept first command within 1ms of supply reaching minimum level.
// - Up to 74 card clocks of preparation before first command.
// - Every power-up, including hot insertion, starts in idle state.
// - Lane card ready for PHY init 1ms after later supply.
// - PCIe card supports second supply, optional low voltage, never both.
// ****************************************
`timescale 1ns/1ps
module card_power_up_sequencer
  import card_pwr_pkg::*;
#(
  parameter int unsigned READY_CNT = READY_CYCLES,
  parameter bit LOW_V_SUPPORT = 1'b1
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Interface kind of this card
  input wire logic [1:0] iface_mode,
  // Supply detector pins
  input wire logic main_supply_ok,
  input wire logic second_supply_ok,
  input wire logic low_voltage_second_supply_ok,
  // Card clock and command line pins
  input wire logic card_clock,
  input wire logic cmd_line,
  // Status toward the card core
  output logic cmd_ready,
  output logic phy_init_ready,
  output logic in_idle,
  output logic supply_fault,
  output logic core_reset_n
);
  // ****************************************
  // Pin synchronisation
  // ****************************************
  supply_sync_if sup ();
  supply_sync u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .raw_ok({low_voltage_second_supply_ok, second_supply_ok, main_supply_ok}),
    .sync(sup)
  );
  logic [1:0] ck_s_q;
  logic [1:0] ck_s_d;
  logic ck_prev_q;
  logic ck_prev_d;
  always_comb begin
    ck_s_d = clk_en ? {ck_s_q[0], card_clock} : ck_s_q;
    ck_prev_d = clk_en ? ck_s_q[1] : ck_prev_q;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ck_s_q <= 2'h0;
      ck_prev_q <= 1'b0;
    end else begin
      ck_s_q <= ck_s_d;
      ck_prev_q <= ck_prev_d;
    end
  end
  wire clk_rise = ck_s_q[1] & ~ck_prev_q;
  // ****************************************
  // Supply qualification
  // ****************************************
  logic lane_kind;
  logic pcie_kind;
  logic both_second;
  logic powered;
  always_comb begin
    lane_kind = (iface_mode == IFACE_LANE);
    pcie_kind = (iface_mode == IFACE_PCIE);
    // In PCIe mode, second and low-voltage supplies together are never accepted
    both_second = pcie_kind & sup.second_ok & sup.low_v_ok;
    if (lane_kind) begin
      // Readiness counts from the later of the two supplies
      powered = sup.main_ok & sup.second_ok;
    end else if (pcie_kind) begin
      // Second supply, or the low-voltage one when built, is required
      powered = sup.main_ok & (sup.second_ok | (LOW_V_SUPPORT & sup.low_v_ok));
    end else begin
      powered = sup.main_ok;
    end
  end
  // ****************************************
  // Sequencer
  // ****************************************
  pwr_state_t st_q;
  pwr_state_t st_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [6:0] clks_q;
  logic [6:0] clks_d;
  logic ready_q;
  logic ready_d;
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    clks_d = clks_q;
    ready_d = ready_q;
    if (clk_en) begin
      case (st_q)
        ST_OFF: begin
          cnt_d = '0;
          clks_d = 7'h00;
          ready_d = 1'b0;
          if (powered && !both_second) begin
            st_d = ST_PREP;
          end
        end
        ST_PREP: begin
          // Prepare from detection; readiness never exceeds the deadline
          if (cnt_q < CNT_W'(READY_CNT - 1)) begin
            cnt_d = cnt_q + CNT_W'(1);
          end
          // Only preparation clocks with the command line idle-high count
          if (clk_rise && cmd_line && clks_q < 7'(PREP_CLOCKS)) begin
            clks_d = clks_q + 7'h01;
          end
          // Ready after 74 idle-high clock rises, or at the READY_CNT deadline at the latest
          if (cnt_q >= CNT_W'(READY_CNT - 1) || clks_q >= 7'(PREP_CLOCKS)) begin
            st_d = ST_IDLE;
            ready_d = 1'b1;
          end
        end
        ST_IDLE: begin
          ready_d = 1'b1;
        end
        ST_FAULT: begin
          // Once the dual supply clears, start over from off so readiness is re-earned
          st_d = ST_OFF;
          ready_d = 1'b0;
        end
        default: begin
          st_d = ST_OFF;
        end
      endcase
      // Loss of supply returns to off; a new power-up restarts in idle
      if (!powered) begin
        st_d = ST_OFF;
        ready_d = 1'b0;
      end else if (both_second) begin
        st_d = ST_FAULT;
        ready_d = 1'b0;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= ST_OFF;
      cnt_q <= '0;
      clks_q <= 7'h00;
      ready_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      clks_q <= clks_d;
      ready_q <= ready_d;
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  logic lane_q;
  logic lane_d;
  always_comb begin
    lane_d = clk_en ? lane_kind : lane_q;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lane_q <= 1'b0;
    end else begin
      lane_q <= lane_d;
    end
  end
  // Core held in reset until idle, so it always wakes in idle state
  assign core_reset_n = ready_q;
  assign in_idle = ready_q;
  assign cmd_ready = ready_q & ~lane_q;
  assign phy_init_ready = ready_q & lane_q;
  assign supply_fault = (st_q == ST_FAULT);
endmodule

// [test/card_pwr_host.sv]
// Host model: card clock burst and command line
`timescale 1ns/1ps
module card_pwr_host (
  // Clock
  input wire logic core_clk,
  // Control from the bench
  input wire logic pwr_on,
  input wire logic cmd_hi,
  // Card pins
  output logic card_clock = 1'b0,
  output logic cmd_line = 1'b0
);
  int n = 0;
  always @(posedge core_clk) begin
    if (!pwr_on) begin
      n <= 0;
      card_clock <= 1'b0;
      cmd_line <= 1'b0;
    end else begin
      n <= n + 1;
      cmd_line <= cmd_hi;
      // Short settle wait, then 74 rises; clock stands still afterwards
      if (n >= 40 && n < 40 + 74 * 8) card_clock <= n[2];
    end
  end
endmodule

// [test/card_pwr_asserts.sv]
// Port checker for the card power-up sequencer
`timescale 1ns/1ps
module card_pwr_asserts
  import card_pwr_pkg::*;
#(parameter int unsigned READY_CNT = 200) (
  input wire logic core_clk, rst_n, clk_en, main_supply_ok, second_supply_ok,
  input wire logic low_voltage_second_supply_ok, card_clock, cmd_line,
  input wire logic [1:0] iface_mode,
  input wire logic cmd_ready, phy_init_ready, in_idle, supply_fault, core_reset_n
);
  logic up;
  logic ck_q;
  int cnt_q, cnt_d, qc_q, qc_d;
  // Raw pins lead the synchronisers, so these counts never lag the design, except cnt_q on PCIe low voltage alone or both second supplies outside PCIe
  assign up = main_supply_ok && (!iface_mode[1] || second_supply_ok)
    && !(second_supply_ok && low_voltage_second_supply_ok);
  always_comb begin
    cnt_d = up ? cnt_q + 1 : 0;
    qc_d = !main_supply_ok ? 0 : qc_q + int'(card_clock && !ck_q && cmd_line);
  end
  always_ff @(posedge core_clk) begin
    cnt_q <= rst_n ? cnt_d : 0;
    qc_q <= rst_n ? qc_d : 0;
    ck_q <= card_clock;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_off;
    !main_supply_ok [*4];
  endsequence
  sequence s_both;
    iface_mode == IFACE_PCIE && second_supply_ok && low_voltage_second_supply_ok;
  endsequence
  chk_bus_deadline: assert property (cnt_q > READY_CNT + 6 && !iface_mode[1] |-> cmd_ready)
    else $error("cmd_ready late");
  chk_prep_count: assert property ($rose(in_idle) |-> qc_q >= 74 || cnt_q >= READY_CNT - 1)
    else $error("idle too early");
  chk_idle_drop: assert property (s_off |=> !in_idle && !core_reset_n)
    else $error("idle held without supply");
  chk_lane_deadline: assert property (cnt_q > READY_CNT + 6 && iface_mode == IFACE_LANE |-> phy_init_ready)
    else $error("phy_init_ready late");
  chk_dual_fault: assert property (s_both [*4] |=> supply_fault && !in_idle && !cmd_ready)
    else $error("dual supply not refused");
endmodule
bind card_power_up_sequencer card_pwr_asserts #(.READY_CNT(READY_CNT)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .main_supply_ok(main_supply_ok),
  .second_supply_ok(second_supply_ok), .card_clock(card_clock), .cmd_line(cmd_line),
  .low_voltage_second_supply_ok(low_voltage_second_supply_ok), .iface_mode(iface_mode),
  .cmd_ready(cmd_ready), .phy_init_ready(phy_init_ready), .in_idle(in_idle),
  .supply_fault(supply_fault), .core_reset_n(core_reset_n));

// [test/card_power_up_sequencer_bench.sv]
// Bench for the card power-up sequencer
`timescale 1ns/1ps
module card_power_up_sequencer_bench;
  import card_pwr_pkg::*;
  // Short deadline keeps the run small; 74 clocks still finish well before it
  localparam int unsigned RC = 2000;
  logic core_clk = 1'b0, rst_n = 1'b0, m_ok = 1'b0, s_ok = 1'b0, l_ok = 1'b0, cmd_hi = 1'b1;
  logic [1:0] mode = IFACE_BUS;
  logic card_clock, cmd_line, cmd_ready, phy_init_ready, in_idle, supply_fault, core_reset_n;
  int fail_count = 0, compares = 0, cyc = 0;
  always #2 core_clk = ~core_clk;
  card_pwr_host u_host (.core_clk(core_clk), .pwr_on(m_ok), .cmd_hi(cmd_hi),
    .card_clock(card_clock), .cmd_line(cmd_line));
  card_power_up_sequencer #(.READY_CNT(RC)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .clk_en(1'b1), .iface_mode(mode), .main_supply_ok(m_ok), .second_supply_ok(s_ok),
    .low_voltage_second_supply_ok(l_ok), .card_clock(card_clock), .cmd_line(cmd_line),
    .cmd_ready(cmd_ready), .phy_init_ready(phy_init_ready), .in_idle(in_idle),
    .supply_fault(supply_fault), .core_reset_n(core_reset_n));
  task automatic check(string what, logic seen, logic exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wrap_up();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Drop all supplies, then raise the chosen set in the chosen mode
  task automatic power(logic s, logic l, logic [1:0] md);
    m_ok <= 1'b0;
    s_ok <= 1'b0;
    l_ok <= 1'b0;
    step(10);
    check("in_idle off", in_idle, 1'b0);
    mode <= md;
    m_ok <= 1'b1;
    s_ok <= s;
    l_ok <= l;
  endtask
  task automatic t_burst();
    power(1'b0, 1'b0, IFACE_BUS);
    step(40 + 74 * 8 + 20);
    check("cmd_ready", cmd_ready, 1'b1);
    check("in_idle", in_idle, 1'b1);
    check("core_reset_n", core_reset_n, 1'b1);
    $display("burst test done");
  endtask
  task automatic t_deadline();
    cmd_hi <= 1'b0;
    power(1'b0, 1'b0, IFACE_SPI);
    step(1000);
    check("cmd_ready early", cmd_ready, 1'b0);
    step(RC);
    check("cmd_ready deadline", cmd_ready, 1'b1);
    cmd_hi <= 1'b1;
    $display("deadline test done");
  endtask
  task automatic t_lane();
    power(1'b0, 1'b0, IFACE_LANE);
    step(RC + 50);
    check("phy_init_ready one supply", phy_init_ready, 1'b0);
    s_ok <= 1'b1;
    step(RC + 20);
    check("phy_init_ready", phy_init_ready, 1'b1);
    $display("lane test done");
  endtask
  task automatic t_pcie();
    power(1'b1, 1'b1, IFACE_PCIE);
    step(20);
    check("supply_fault", supply_fault, 1'b1);
    check("in_idle fault", in_idle, 1'b0);
    l_ok <= 1'b0;
    step(RC + 20);
    check("supply_fault clear", supply_fault, 1'b0);
    check("in_idle pcie", in_idle, 1'b1);
    $display("pcie test done");
  endtask
  // Hang guard well above the roughly 9800 cycles the tests need
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    step(4);
    rst_n <= 1'b1;
    t_burst();
    t_deadline();
    t_lane();
    t_pcie();
    wrap_up();
  end
endmodule
